/* glf_regs.vh */
/*
  glf_regs.vh: register indices, field positions, reset values and
  memory figures for the gray look-up virtual line fetch block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef GLF_REGS_VH
`define GLF_REGS_VH

// register indices; byte address is four times the index
`define GLF_IDX_START0      8'h0C
`define GLF_IDX_START1      8'h0D
`define GLF_IDX_START2      8'h10
`define GLF_IDX_LINE_EXTRA  8'h11
`define GLF_IDX_MODE        8'h20
`define GLF_IDX_HWIDTH      8'h21
`define GLF_IDX_VLINES      8'h22
`define GLF_IDX_STATUS      8'h23
`define GLF_IDX_PAL_INDEX   8'h24
`define GLF_IDX_PAL_DATA    8'h25
`define GLF_IDX_FETCH_ADDR  8'h26

// mode register fields
`define GLF_MODE_BPP_LSB    0
`define GLF_MODE_BPP_MSB    1
`define GLF_MODE_EN_BIT     2

// depth codes: bits per pixel is 1 << code
`define GLF_BPP_1           2'h0
`define GLF_BPP_2           2'h1
`define GLF_BPP_4           2'h2
`define GLF_BPP_8           2'h3

// status register fields
`define GLF_STAT_BUSY_BIT   0
`define GLF_STAT_MERR_BIT   1
`define GLF_STAT_LINE_LSB   8

// palette entry layout {red, green, blue}, four bits each
`define GLF_PAL_G_MSB       7
`define GLF_PAL_G_LSB       4

// reset values
`define GLF_RST_LINE_EXTRA  8'h00
`define GLF_RST_START       17'h0_0000
`define GLF_RST_MODE        3'h0
`define GLF_RST_HWIDTH      8'h00
`define GLF_RST_VLINES      9'h000

// display memory: 81920 bytes held as 16-bit words
`define GLF_MEM_BYTES       81920
`define GLF_MEM_WORDS       18'h0_A000
`define GLF_WORD_BITS       16

`endif

/* glf_fifo.v */
/*
  glf_fifo: synchronous FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-high reset, clock enable.
*/
`timescale 1ns/1ps
module glf_fifo #(
  parameter W  = 18,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         ref_clk,
  input  wire         srst,
  input  wire         ce,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  // honest flags straight from the fill count
  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset, pointers do
  always @(posedge ref_clk) begin
    if (ce && push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers wrap at D; D must be a power of two
  always @(posedge ref_clk) begin
    if (srst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // glf_fifo

/* glf_pix_sel.v */
/*
  glf_pix_sel: picks pixel k of a 16-bit buffer word as a table index.
  Low byte is shown first, each byte most significant pixel first.
  Assumes a depth code of 1, 2 or 4 bits per pixel.
*/
`timescale 1ns/1ps
`include "glf_regs.vh"
module glf_pix_sel (
  input  wire [15:0] word,
  input  wire [1:0]  bpp,
  input  wire [3:0]  k,
  output reg  [3:0]  code
);
  reg [3:0]  sh;
  reg [15:0] shifted;

  // bit position of the pixel's least significant bit
  always @* begin
    sh      = 4'h0;
    shifted = 16'h0000;
    code    = 4'h0;
    case (bpp)
      `GLF_BPP_1: begin
        sh   = {k[3], ~k[2:0]};
        code = {3'b000, word[sh]};          // eight per byte
      end
      `GLF_BPP_2: begin
        sh      = {k[2], ~k[1:0], 1'b0};
        shifted = word >> sh;
        code    = {2'b00, shifted[1:0]};    // only entries 0..3
      end
      `GLF_BPP_4: begin
        sh      = {k[1], ~k[0], 2'b00};
        shifted = word >> sh;
        code    = shifted[3:0];             // nibble picks 0..15
      end
      default: begin
        code = 4'h0;
      end
    endcase
  end
endmodule // glf_pix_sel

/* glf_gray_fetch.v */
/*
  glf_gray_fetch: gray shade pixel path with virtual line stride.
  Fetches 16-bit display words line by line, buffers them, unpacks
  pixels and looks up their green intensity for the panel.
  Assumes panel timing gives a one-cycle frame_start on ref_clk, the
  display memory answers each read once with mem_rd_valid, and the
  host uses Avalon-MM with waitrequest.
  Leaves colour modes, panel timing and rotation to other blocks.
*/
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "glf_regs.vh"
module glf_gray_fetch (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        ce,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        frame_start,
  output reg         mem_rd_req,
  output wire [16:0] mem_addr,
  input  wire        mem_rd_valid,
  input  wire [15:0] mem_rd_data,
  output reg         pix_valid,
  input  wire        pix_ready,
  output reg  [3:0]  pix_gray,
  output reg         pix_line_end,
  output reg         pix_frame_first
);
  // fetch states, one-hot; a stray code falls back to idle through
  // the default branch, so a glitched state cannot lock the fetch
  localparam S_IDLE = 3'b001;
  localparam S_REQ  = 3'b010;
  localparam S_WAIT = 3'b100;

  // software registers; the start is split over three indices, but it
  // is sampled once at frame start, so a half-written start can only
  // spoil a single frame
  reg [7:0]  line_extra_words_q;
  reg [16:0] start_q;
  reg [2:0]  mode_q;
  reg [7:0]  hwidth_q;
  reg [8:0]  vlines_q;
  reg [7:0]  pal_idx_q;
  reg [11:0] palette_table [0:255];
  reg        ack_q;

  // fetch state; base_q keeps the first word of the current line so
  // the stride is added to the line start, not to where the line ended
  reg [2:0]  st_q;
  reg [16:0] addr_q;
  reg [16:0] base_q;
  reg [7:0]  wcnt_q;
  reg [8:0]  lcnt_q;
  reg [1:0]  fbpp_q;
  reg        first_q;

  // unpack state; word_q carries {line end, frame first, data}
  // and k_q counts pixels inside the word currently held
  reg [17:0] word_q;
  reg        word_vld_q;
  reg [3:0]  k_q;

  // bus decode, fetch control, FIFO and unpack nets
  wire [7:0]  idx;
  wire        acc;
  wire [1:0]  bpp_sel;
  wire        mode_bad;
  wire        can_start;
  wire [8:0]  stride;
  wire        last_word;
  wire        last_line;
  wire        f_in_valid;
  wire        f_in_ready;
  wire        f_out_valid;
  wire        f_out_ready;
  wire [17:0] f_out_data;
  wire [3:0]  ppw_m1;
  wire        take;
  wire        last_pix;
  wire [3:0]  code;
  wire [11:0] entry;
  reg  [31:0] rd_mux;

  // keeps an address inside display memory by one subtraction
  // enough for any start below twice the memory size; a larger start
  // is not fully reduced and counts as a software fault
  function [16:0] wrap;
    input [17:0] a;
    reg   [17:0] t;
    begin
      t    = (a >= `GLF_MEM_WORDS) ? (a - `GLF_MEM_WORDS) : a;
      wrap = t[16:0];
    end
  endfunction

  // byte address to register index; the low two bits are ignored
  assign idx      = avs_address[9:2];
  assign acc      = (avs_read | avs_write) & ~ack_q;
  assign bpp_sel  = mode_q[`GLF_MODE_BPP_MSB:`GLF_MODE_BPP_LSB];
  assign mode_bad = (bpp_sel == `GLF_BPP_8);
  assign can_start = mode_q[`GLF_MODE_EN_BIT] & ~mode_bad
                   & (hwidth_q != 8'h00) & (vlines_q != 9'h000);
  // virtual line in words: shown width plus extra words
  // nine bits hold 255 + 255 without overflow
  assign stride    = {1'b0, hwidth_q} + {1'b0, line_extra_words_q};
  assign last_word = (wcnt_q == hwidth_q - 8'h01);
  assign last_line = (lcnt_q == vlines_q - 9'h001);
  assign mem_addr  = addr_q;

  // one wait cycle per access, answer on the next edge
  // ack_q splits a held request into a two-cycle access, so a
  // request that stays up is never taken twice
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  // register read mux; unmapped indices read zero
  // busy reads as not idle; the line count shows frame progress
  always @* begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `GLF_IDX_START0:     rd_mux = {24'h00_0000, start_q[7:0]};
      `GLF_IDX_START1:     rd_mux = {24'h00_0000, start_q[15:8]};
      `GLF_IDX_START2:     rd_mux = {31'h0000_0000, start_q[16]};
      `GLF_IDX_LINE_EXTRA: rd_mux = {24'h00_0000, line_extra_words_q};
      `GLF_IDX_MODE:       rd_mux = {29'h0000_0000, mode_q};
      `GLF_IDX_HWIDTH:     rd_mux = {24'h00_0000, hwidth_q};
      `GLF_IDX_VLINES:     rd_mux = {23'h00_0000, vlines_q};
      `GLF_IDX_STATUS:     rd_mux = {15'h0000, lcnt_q, 6'h00, mode_bad, ~st_q[0]};
      `GLF_IDX_PAL_INDEX:  rd_mux = {24'h00_0000, pal_idx_q};
      `GLF_IDX_PAL_DATA:   rd_mux = {20'h0_0000, palette_table[pal_idx_q]};
      `GLF_IDX_FETCH_ADDR: rd_mux = {15'h0000, addr_q};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // bus slave: read data latched when the request is first seen;
  // writes land at the edge where waitrequest is low, which is where
  // the master takes completion, so a write never lands early
  always @(posedge ref_clk) begin
    if (srst) begin
      ack_q              <= 1'b0;
      avs_readdata       <= 32'h0000_0000;
      line_extra_words_q <= `GLF_RST_LINE_EXTRA;
      start_q            <= `GLF_RST_START;
      mode_q             <= `GLF_RST_MODE;
      hwidth_q           <= `GLF_RST_HWIDTH;
      vlines_q           <= `GLF_RST_VLINES;
      pal_idx_q          <= 8'h00;
    end else if (ce) begin
      ack_q <= acc;
      if (acc && avs_read) begin
        avs_readdata <= rd_mux;
        if (idx == `GLF_IDX_PAL_DATA) begin
          pal_idx_q <= pal_idx_q + 8'h01;  // walk the table on reads too
        end
      end
      if (ack_q && avs_write) begin
        case (idx)
          `GLF_IDX_START0:     start_q[7:0]  <= avs_writedata[7:0];
          `GLF_IDX_START1:     start_q[15:8] <= avs_writedata[7:0];
          `GLF_IDX_START2:     start_q[16]   <= avs_writedata[0];
          `GLF_IDX_LINE_EXTRA: line_extra_words_q <= avs_writedata[7:0];
          `GLF_IDX_MODE:       mode_q   <= avs_writedata[2:0];
          `GLF_IDX_HWIDTH:     hwidth_q <= avs_writedata[7:0];
          `GLF_IDX_VLINES:     vlines_q <= avs_writedata[8:0];
          `GLF_IDX_PAL_INDEX:  pal_idx_q <= avs_writedata[7:0];
          `GLF_IDX_PAL_DATA:   pal_idx_q <= pal_idx_q + 8'h01;
          default:             pal_idx_q <= pal_idx_q;
        endcase
      end
    end
  end

  // palette storage; all three components kept for software readback
  // only the green nibble reaches the panel; no reset, so entries
  // read unknown until software loads them
  always @(posedge ref_clk) begin
    if (ce && ack_q && avs_write && idx == `GLF_IDX_PAL_DATA) begin
      palette_table[pal_idx_q] <= avs_writedata[11:0];
    end
  end

  // fetch sequencer: one read outstanding, so a free slot at request
  // time is still free when the word comes back
  // depth is latched with the start, so a mode write mid-frame
  // only takes effect at the next frame
  always @(posedge ref_clk) begin
    if (srst) begin
      st_q       <= S_IDLE;
      addr_q     <= 17'h0_0000;
      base_q     <= 17'h0_0000;
      wcnt_q     <= 8'h00;
      lcnt_q     <= 9'h000;
      fbpp_q     <= `GLF_BPP_1;
      first_q    <= 1'b0;
      mem_rd_req <= 1'b0;
    end else if (ce) begin
      mem_rd_req <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // start of frame at the top-left word
          // a frame_start while busy is ignored; the frame in hand runs out
          if (frame_start && can_start) begin
            addr_q  <= wrap({1'b0, start_q});
            base_q  <= wrap({1'b0, start_q});
            wcnt_q  <= 8'h00;
            lcnt_q  <= 9'h000;
            fbpp_q  <= bpp_sel;
            first_q <= 1'b1;
            st_q    <= S_REQ;
          end
        end
        S_REQ: begin
          // wait for room so the returning word always finds a slot
          if (f_in_ready) begin
            mem_rd_req <= 1'b1;
            st_q       <= S_WAIT;
          end
        end
        S_WAIT: begin
          // one read in flight; the address holds until the answer
          if (mem_rd_valid) begin
            first_q <= 1'b0;
            if (last_word) begin
              wcnt_q <= 8'h00;
              if (last_line) begin
                st_q <= S_IDLE;
              end else begin
                // next line starts one virtual line further on
                addr_q <= wrap({1'b0, base_q} + {9'h000, stride});
                base_q <= wrap({1'b0, base_q} + {9'h000, stride});
                lcnt_q <= lcnt_q + 9'h001;
                st_q   <= S_REQ;
              end
            end else begin
              addr_q <= wrap({1'b0, addr_q} + 18'h0_0001);
              wcnt_q <= wcnt_q + 8'h01;
              st_q   <= S_REQ;
            end
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // words carry their own line-end and frame-first marks
  // the marks ride through the FIFO with the data, so the unpacker
  // needs no line or frame counters of its own
  assign f_in_valid = st_q[2] & mem_rd_valid;

  // eight words cover the panel's stalls while one read is in flight
  glf_fifo #(
    .W  (18),
    .D  (8),
    .AW (3)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   ({last_word, first_q, mem_rd_data}),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // pixels per word less one: 16 >> code, minus one
  // a new word leaves the FIFO in the cycle the last pixel of the
  // old one leaves, so a word change costs no bubble
  assign ppw_m1   = 4'hF >> fbpp_q;
  assign take     = word_vld_q & (~pix_valid | pix_ready);
  assign last_pix = (k_q == ppw_m1);
  assign f_out_ready = ~word_vld_q | (take & last_pix);

  // pixel picker; pure logic on the held word
  glf_pix_sel u_sel (
    .word (word_q[15:0]),
    .bpp  (fbpp_q),
    .k    (k_q),
    .code (code)
  );

  // 1 bpp index is 0 or 1, so only two entries reach the lookup
  // 2 bpp index is 0..3; the upper index nibble is zero at every
  // depth, so entries above 15 never reach the panel
  assign entry = palette_table[{4'h0, code}];

  // unpack and output stage; panel stalls through pix_ready
  // pix_valid stays high with its data until the panel takes it;
  // a new pixel may follow in the very next cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      word_q          <= 18'h0_0000;
      word_vld_q      <= 1'b0;
      k_q             <= 4'h0;
      pix_valid       <= 1'b0;
      pix_gray        <= 4'h0;
      pix_line_end    <= 1'b0;
      pix_frame_first <= 1'b0;
    end else if (ce) begin
      // move a pixel out when the output register is free or emptying
      if (take) begin
        pix_valid       <= 1'b1;
        pix_gray        <= entry[`GLF_PAL_G_MSB:`GLF_PAL_G_LSB];
        pix_line_end    <= word_q[17] & last_pix;
        pix_frame_first <= word_q[16] & (k_q == 4'h0);
        k_q             <= last_pix ? 4'h0 : k_q + 4'h1;
      end else if (pix_ready) begin
        pix_valid <= 1'b0;
      end
      // load the next word as the last pixel of this one leaves
      if (f_out_valid && f_out_ready) begin
        word_q     <= f_out_data;
        word_vld_q <= 1'b1;
      end else if (take && last_pix) begin
        word_vld_q <= 1'b0;
      end
    end
  end
endmodule // glf_gray_fetch

/* glf_gray_fetch_assertions.sv */
/* glf_gray_fetch_chk: port-level checks for glf_gray_fetch.
   Assumes one clock, srst synchronous active high, bound by name. */
`timescale 1ns/1ps
module glf_gray_fetch_chk (
  input wire        ref_clk,
  input wire        srst,
  input wire        ce,
  input wire [9:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        frame_start,
  input wire        mem_rd_req,
  input wire [16:0] mem_addr,
  input wire        mem_rd_valid,
  input wire [15:0] mem_rd_data,
  input wire        pix_valid,
  input wire        pix_ready,
  input wire [3:0]  pix_gray,
  input wire        pix_line_end,
  input wire        pix_frame_first
);
  reg pend_q;
  // one memory read in flight between request and answer
  always @(posedge ref_clk) begin
    if (srst || mem_rd_valid) pend_q <= 1'b0;
    else if (mem_rd_req) pend_q <= 1'b1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest && ce
    |=> !avs_waitrequest) else $error("bus wait longer than one cycle");
  a_wait_idle_low: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait asserted without request");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_req_pulse: assert property (mem_rd_req |=> !mem_rd_req)
    else $error("memory request longer than one cycle");
  a_addr_held: assert property ((mem_rd_req || pend_q) && !mem_rd_valid
    |=> $stable(mem_addr)) else $error("fetch address moved in flight");
  a_one_flight: assert property (pend_q |-> !mem_rd_req)
    else $error("second read while one in flight");
  a_next_req_gap: assert property (mem_rd_valid |=> !mem_rd_req)
    else $error("request right after answer");
  a_pix_hold: assert property (pix_valid && !pix_ready |=> pix_valid
    && $stable({pix_gray, pix_line_end, pix_frame_first})) else $error("pixel dropped");
  a_reset_quiet: assert property ($fell(srst) |-> !mem_rd_req && !pix_valid
    && pix_gray == 4'h0) else $error("outputs active out of reset");
  c_mem_read: cover property (mem_rd_req);
  c_line_end: cover property (pix_valid && pix_ready && pix_line_end);
  c_reg_read: cover property (avs_read && !avs_waitrequest);
endmodule // glf_gray_fetch_chk

bind glf_gray_fetch glf_gray_fetch_chk chk_u (
  .ref_clk(ref_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .frame_start(frame_start), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
  .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .pix_valid(pix_valid),
  .pix_ready(pix_ready), .pix_gray(pix_gray), .pix_line_end(pix_line_end),
  .pix_frame_first(pix_frame_first));

/* glf_panel_mem.sv */
/* glf_panel_mem: display memory and gray panel facing the fetch block.
   Assumes one clock; the word at address a is a fixed pattern of a. */
`timescale 1ns/1ps
module glf_panel_mem (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        mem_rd_req,
  input  wire [16:0] mem_addr,
  output reg         mem_rd_valid,
  output reg  [15:0] mem_rd_data,
  output wire        pix_ready
);
  reg [16:0] addr_q;
  reg [1:0]  wait_q;
  reg        busy_q;
  reg        slow_q;
  reg [1:0]  stall_q;
  // panel refuses one cycle in three, so the block must hold its pixel
  assign pix_ready = (stall_q != 2'h0);
  // answers alternate fast and slow; idle data lines flip every cycle
  always @(posedge ref_clk) begin
    mem_rd_valid <= 1'b0;
    mem_rd_data <= ~mem_rd_data;
    stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
    if (srst) begin
      busy_q <= 1'b0;
      slow_q <= 1'b0;
      stall_q <= 2'h0;
      mem_rd_data <= 16'h0000;
    end else if (mem_rd_req) begin
      busy_q <= 1'b1;
      addr_q <= mem_addr;
      wait_q <= slow_q ? 2'h2 : 2'h0;
      slow_q <= ~slow_q;
    end else if (busy_q && wait_q == 2'h0) begin
      busy_q <= 1'b0;
      mem_rd_valid <= 1'b1;
      mem_rd_data <= {addr_q[7:0] ^ 8'h3C, addr_q[7:0] ^ 8'hA5}; // one 16-bit word
    end else if (busy_q) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule // glf_panel_mem

/* glf_gray_fetch_tb.sv */
/* glf_gray_fetch_tb: self-checking bench for glf_gray_fetch.
   Assumes glf_panel_mem as memory and panel, checker bound. */
`timescale 1ns/1ps
`include "glf_regs.vh"
module glf_gray_fetch_tb;
  reg          ref_clk;
  reg          srst;
  reg          ce;
  reg  [9:0]   avs_address;
  reg          avs_read;
  reg          avs_write;
  reg  [31:0]  avs_writedata;
  wire [31:0]  avs_readdata;
  wire         avs_waitrequest;
  reg          frame_start;
  wire         mem_rd_req;
  wire [16:0]  mem_addr;
  wire         mem_rd_valid;
  wire [15:0]  mem_rd_data;
  wire         pix_valid;
  wire         pix_ready;
  wire [3:0]   pix_gray;
  wire         pix_line_end;
  wire         pix_frame_first;
  integer      err_total;
  integer      cmp_count;
  integer      cyc;
  logic [16:0] addr_q[$];
  logic [5:0]  pix_q[$];
  logic [31:0] rd;

  glf_gray_fetch dut_u (.ref_clk(ref_clk), .srst(srst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_start(frame_start),
    .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_gray(pix_gray), .pix_line_end(pix_line_end), .pix_frame_first(pix_frame_first));
  glf_panel_mem mem_u (.ref_clk(ref_clk), .srst(srst), .mem_rd_req(mem_rd_req),
    .mem_addr(mem_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .pix_ready(pix_ready));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // log fetch addresses and accepted pixels; guard against a hang
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (mem_rd_req === 1'b1) addr_q.push_back(mem_addr);
    if (pix_valid === 1'b1 && pix_ready === 1'b1)
      pix_q.push_back({pix_frame_first, pix_line_end, pix_gray});
    if (cyc == 40000) begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // green differs from red and blue in every entry
  function automatic logic [3:0] gr(input logic [3:0] e);
    gr = e ^ 4'h6;
  endfunction
  task automatic frame(input logic [1:0] code, input logic [16:0] s, input logic [7:0] h,
                       input logic [7:0] o, input logic [8:0] v);
    integer l, w, k, b, ppw, p, a;
    logic [7:0] by;
    bus(1'b1, `GLF_IDX_MODE, 32'h0000_0004 + 32'(code));
    bus(1'b1, `GLF_IDX_HWIDTH, 32'(h));
    bus(1'b1, `GLF_IDX_VLINES, 32'(v));
    bus(1'b1, `GLF_IDX_START0, 32'(s[7:0]));
    bus(1'b1, `GLF_IDX_START1, 32'(s[15:8]));
    bus(1'b1, `GLF_IDX_START2, 32'(s[16]));
    bus(1'b1, `GLF_IDX_LINE_EXTRA, 32'(o));
    addr_q.delete();
    pix_q.delete();
    frame_start <= 1'b1;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    b = 1 << code;
    ppw = 16 / b;
    for (p = 0; p < 5000 && pix_q.size() < v * h * ppw; p++) @(posedge ref_clk);
    repeat (10) @(posedge ref_clk);
    chk(addr_q.size(), v * h);
    chk(pix_q.size(), v * h * ppw);
    for (l = 0; l < v; l++) for (w = 0; w < h; w++) begin
      a = (s + l * (h + o) + w) % 40960;
      chk(32'(addr_q[l * h + w]), a);
      for (k = 0; k < ppw; k++) begin
        by = (k < ppw / 2) ? (a[7:0] ^ 8'hA5) : (a[7:0] ^ 8'h3C);
        p = (by >> (8 - b * (k % (ppw / 2) + 1))) & ((1 << b) - 1);
        chk(32'(pix_q[(l * h + w) * ppw + k]), {l == 0 && w == 0 && k == 0,
            w == h - 1 && k == ppw - 1, gr(p[3:0])});
      end
    end
  endtask

  task automatic t_regs;
    bus(1'b0, `GLF_IDX_LINE_EXTRA, 32'h0000_0000);
    chk(rd, 32'(`GLF_RST_LINE_EXTRA));
    bus(1'b1, `GLF_IDX_LINE_EXTRA, 32'hFFFF_FFFF);
    bus(1'b0, `GLF_IDX_LINE_EXTRA, 32'h0000_0000);
    chk(rd, 32'h0000_00FF);
    bus(1'b1, 8'h3F, 32'hFFFF_FFFF);
    bus(1'b0, 8'h3F, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, `GLF_IDX_START1, 32'h0000_00A5);
    bus(1'b0, `GLF_IDX_START1, 32'h0000_0000);
    chk(rd, 32'h0000_00A5);
    $display("test regs done");
  endtask
  task automatic t_gray8;
    bus(1'b1, `GLF_IDX_MODE, 32'h0000_0007);
    addr_q.delete();
    pix_q.delete();
    frame_start <= 1'b1;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk(addr_q.size() + pix_q.size(), 0);
    bus(1'b0, `GLF_IDX_STATUS, 32'h0000_0000);
    chk(32'(rd[`GLF_STAT_MERR_BIT]), 1);
    $display("test 8bpp refused done");
  endtask

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // reset, check registers, load the table, then one frame each at 1, 2 and 4 bpp and a refused 8 bpp start
  initial begin : main
    integer e;
    srst = 1'b1;
    ce = 1'b1;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    frame_start = 1'b0;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs();
    bus(1'b1, `GLF_IDX_PAL_INDEX, 32'h0000_0000);
    for (e = 0; e < 16; e++)
      bus(1'b1, `GLF_IDX_PAL_DATA, {20'h0_0000, ~gr(e[3:0]), gr(e[3:0]), e[3:0] + 4'h1});
    bus(1'b1, `GLF_IDX_PAL_INDEX, 32'h0000_0001);
    bus(1'b0, `GLF_IDX_PAL_DATA, 32'h0000_0000);
    chk(rd, {20'h0_0000, ~gr(4'h1), gr(4'h1), 4'h2});
    frame(`GLF_BPP_1, 17'h0_9FFE, 8'h03, 8'h03, 9'h002); // wraps at top of memory
    $display("test 1bpp done");
    frame(`GLF_BPP_2, 17'h0_0100, 8'h02, 8'h00, 9'h002); // no virtual width
    $display("test 2bpp done");
    frame(`GLF_BPP_4, 17'h1_0010, 8'h02, 8'hFF, 9'h003); // widest offset
    $display("test 4bpp done");
    t_gray8();
    tally_and_finish();
  end
endmodule // glf_gray_fetch_tb
